// ### verification/gct_bus_ctl.sv
// Bus controller model: sends command bytes and reads poll bytes.
// Assumes resolved line levels come back in, high when released.
`timescale 1ns/1ns
module gct_bus_ctl (
	// Clock.
	input wire logic clk,
	// Resolved lines.
	input wire logic dav_ln,
	input wire logic nrfd_ln,
	input wire logic ndac_ln,
	input wire logic [7:0] dio_ln,
	// Controller pull-down enables and attention.
	output logic atn_n,
	output logic dav_oe,
	output logic nrfd_oe,
	output logic ndac_oe,
	output logic [7:0] dio_oe
);
	initial begin
		atn_n = 1'b1;
		dav_oe = 1'b0;
		nrfd_oe = 1'b0;
		ndac_oe = 1'b0;
		dio_oe = 8'h00;
	end
	// Sources one byte; data is held until every acceptor lets go of NDAC.
	task automatic send(input logic atn, input logic [7:0] b);
		@(negedge clk);
		atn_n = !atn;
		dio_oe = b;
		nrfd_oe = 1'b0;
		ndac_oe = 1'b0;
		// Devices need a few cycles to see attention before their lines mean anything.
		repeat (4) @(negedge clk);
		for (int i = 0; i < 99 && !nrfd_ln; i++) @(negedge clk);
		dav_oe = 1'b1;
		for (int i = 0; i < 99 && !ndac_ln; i++) @(negedge clk);
		dav_oe = 1'b0;
		dio_oe = 8'h00;
		for (int i = 0; i < 99 && ndac_ln; i++) @(negedge clk);
	endtask
	// Reads one byte with attention released; no talker gives all ones on the lines.
	task automatic poll(output logic [7:0] b);
		@(negedge clk);
		atn_n = 1'b1;
		ndac_oe = 1'b1;
		nrfd_oe = 1'b0;
		for (int i = 0; i < 40 && dav_ln; i++) @(negedge clk);
		b = ~dio_ln;
		nrfd_oe = 1'b1;
		ndac_oe = 1'b0;
		for (int i = 0; i < 99 && !dav_ln; i++) @(negedge clk);
		ndac_oe = 1'b1;
	endtask
endmodule

// ### verification/gct_clear_trigger_poll_props.sv
// Checker for the bus clear, trigger and serial poll block.
// Assumes it sees only the block's ports, on the one core clock.
`timescale 1ns/1ns
module gct_ctp_props (
	// Clock and reset.
	input wire logic core_clk,
	input wire logic rstn,
	// Bus pull-down enables and instrument side.
	input wire logic nrfd_n_oe,
	input wire logic srq_n_oe,
	input wire logic [7:0] dio_n_oe,
	input wire logic [7:0] status_byte,
	input wire gct_pkg::gct_meas_s setup1,
	input wire gct_pkg::gct_cfg_s cfg,
	input wire logic drift_clr,
	input wire logic meas_start,
	input wire logic sweep_start,
	input wire logic restore_busy,
	input wire logic listen_active,
	input wire logic talk_active,
	input wire logic poll_enabled
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);
	// The restore must never let a new byte in before it ends.
	a_hold_restore: assert property (restore_busy |-> nrfd_n_oe)
		else $error("ready released during restore");
	a_restore_len: assert property ($rose(restore_busy) |-> restore_busy [*4] ##1 !restore_busy)
		else $error("restore length wrong");
	a_drift_end: assert property ($fell(restore_busy) |-> drift_clr && !cfg.drift_correction_setting)
		else $error("drift correction kept");
	a_drift_cause: assert property (drift_clr |-> $fell(restore_busy))
		else $error("drift discard without clear");
	a_slot_reload: assert property ($fell(restore_busy) |-> cfg.meas == $past(setup1))
		else $error("modes not taken from slot");
	a_fixed_dflt: assert property ($fell(restore_busy) |->
		cfg.srq_mask == gct_pkg::SERVICE_REQUEST_MASK_DEFAULT &&
		cfg.term_code == gct_pkg::TERMINATOR_CODE_DEFAULT)
		else $error("fixed defaults not restored");
	a_trig_gate: assert property ((meas_start || sweep_start) |->
		cfg.meas.trig_src == gct_pkg::TRIG_SRC_GET && listen_active)
		else $error("trigger without bus source");
	a_trig_mode: assert property ((meas_start || sweep_start) |->
		sweep_start == cfg.meas.trig_sweep && meas_start != sweep_start)
		else $error("wrong trigger mode start");
	a_poll_talker: assert property (|dio_n_oe |-> talk_active && poll_enabled)
		else $error("data driven outside poll");
	a_poll_byte: assert property ($rose(|dio_n_oe) |->
		dio_n_oe == {status_byte[7], srq_n_oe, status_byte[5:0]})
		else $error("status byte wrong");
endmodule
bind gct_clear_trigger_poll gct_ctp_props u_props (.core_clk, .rstn, .nrfd_n_oe, .srq_n_oe,
	.dio_n_oe, .status_byte, .setup1, .cfg, .drift_clr, .meas_start, .sweep_start,
	.restore_busy, .listen_active, .talk_active, .poll_enabled);

// ### verification/gct_clear_trigger_poll_tb.sv
// Testbench for the bus clear, trigger and serial poll block.
// Assumes the controller model drives the bus and pads resolve as open drain.
`timescale 1ns/1ns
module gct_clear_trigger_poll_tb;
	localparam logic [4:0] ADDR = 5'h0A;
	logic core_clk, rstn, cfg_wr, srq_req, c_dav, c_nrfd, c_ndac;
	logic dav_n_oe, nrfd_n_oe, ndac_n_oe, srq_n_oe, drift_clr, meas_start, sweep_start;
	logic restore_busy, listen_active, talk_active, poll_enabled, rx_valid;
	logic [7:0] dio_n_oe, c_dio, status_byte, b, rx_data;
	wire atn_n_i;
	gct_pkg::gct_meas_s setup1;
	gct_pkg::gct_cfg_s cfg_wdata, cfg, v;
	int error_cnt, n_tests, n_drift, n_meas, n_sweep, n_rx, m0, s0;
	// Open-drain lines: low when any party pulls.
	wire dav_n_i = ~(dav_n_oe | c_dav);
	wire nrfd_n_i = ~(nrfd_n_oe | c_nrfd);
	wire ndac_n_i = ~(ndac_n_oe | c_ndac);
	wire [7:0] dio_n_i = ~(dio_n_oe | c_dio);
	gct_clear_trigger_poll uut (.core_clk, .rstn, .atn_n_i, .dav_n_i, .dav_n_o(), .dav_n_oe,
		.nrfd_n_i, .nrfd_n_o(), .nrfd_n_oe, .ndac_n_i, .ndac_n_o(), .ndac_n_oe, .srq_n_o(),
		.srq_n_oe, .dio_n_i, .dio_n_o(), .dio_n_oe, .bus_addr(ADDR), .setup1, .cfg_wr,
		.cfg_wdata, .status_byte, .srq_req, .cfg, .drift_clr, .meas_start, .sweep_start,
		.restore_busy, .listen_active, .talk_active, .poll_enabled, .rx_valid, .rx_data);
	gct_bus_ctl ctl (.clk(core_clk), .dav_ln(dav_n_i), .nrfd_ln(nrfd_n_i), .ndac_ln(ndac_n_i),
		.dio_ln(dio_n_i), .atn_n(atn_n_i), .dav_oe(c_dav), .nrfd_oe(c_nrfd),
		.ndac_oe(c_ndac), .dio_oe(c_dio));
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	// Pulse counters, so short pulses are never missed between checks.
	always @(posedge core_clk) begin
		if (drift_clr === 1'b1) n_drift++;
		if (meas_start === 1'b1) n_meas++;
		if (sweep_start === 1'b1) n_sweep++;
		if (rx_valid === 1'b1) n_rx++;
	end
	task automatic chk(input logic [79:0] got, input logic [79:0] exp);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask
	task automatic wr_cfg(input gct_pkg::gct_cfg_s d);
		@(negedge core_clk);
		cfg_wdata = d;
		cfg_wr = 1'b1;
		@(negedge core_clk);
		cfg_wr = 1'b0;
	endtask
	task automatic t_reset;
		chk(cfg.meas, setup1);
		chk(cfg.meas.bias_count, 16'h01C2);
		chk(cfg.srq_mask, gct_pkg::SERVICE_REQUEST_MASK_DEFAULT);
		chk(n_drift, 1);
	endtask
	// Scrambled set with drift on, then a universal clear with a changed slot.
	task automatic t_dcl;
		v = '1;
		wr_cfg(v);
		chk(cfg, v);
		setup1.rate_code = 3'h5;
		ctl.send(1'b1, gct_pkg::CMD_DCL);
		chk(cfg, {setup1, 8'h00, 2'h0, 1'b0});
		chk(n_drift, 2);
	endtask
	task automatic t_sdc;
		wr_cfg(v);
		ctl.send(1'b1, gct_pkg::CMD_UNL);
		ctl.send(1'b1, gct_pkg::CMD_SDC);
		chk(cfg, v);
		ctl.send(1'b1, {gct_pkg::GRP_LISTEN, ADDR});
		chk(listen_active, 1'b1);
		// The clear code sent with attention false is plain data, not a clear.
		ctl.send(1'b0, gct_pkg::CMD_SDC);
		chk(cfg, v);
		chk(n_rx, 1);
		chk(rx_data, gct_pkg::CMD_SDC);
		ctl.send(1'b1, gct_pkg::CMD_SDC);
		chk(cfg.meas, setup1);
		chk(n_drift, 3);
	endtask
	// Trigger with the wrong source, both modes, then unaddressed.
	task automatic t_get;
		m0 = n_meas;
		s0 = n_sweep;
		ctl.send(1'b1, gct_pkg::CMD_GET);
		v = cfg;
		v.meas.trig_src = gct_pkg::TRIG_SRC_GET;
		v.meas.trig_sweep = 1'b0;
		wr_cfg(v);
		ctl.send(1'b1, gct_pkg::CMD_GET);
		chk(n_meas - m0, 1);
		v.meas.trig_sweep = 1'b1;
		wr_cfg(v);
		ctl.send(1'b1, gct_pkg::CMD_GET);
		ctl.send(1'b1, gct_pkg::CMD_UNL);
		ctl.send(1'b1, gct_pkg::CMD_GET);
		chk(n_sweep - s0, 1);
		chk(n_meas - m0, 1);
	endtask
	task automatic t_poll;
		status_byte = 8'hA5;
		@(negedge core_clk);
		srq_req = 1'b1;
		@(negedge core_clk);
		srq_req = 1'b0;
		@(negedge core_clk);
		chk(srq_n_oe, 1'b1);
		ctl.send(1'b1, gct_pkg::CMD_SPE);
		ctl.send(1'b1, {gct_pkg::GRP_TALK, ADDR});
		chk(poll_enabled, 1'b1);
		chk(talk_active, 1'b1);
		ctl.poll(b);
		chk(b, 8'hE5);
		chk(srq_n_oe, 1'b0);
		ctl.send(1'b1, {gct_pkg::GRP_TALK, ADDR + 5'h01});
		chk(talk_active, 1'b0);
		ctl.poll(b);
		chk(b, 8'h00);
		status_byte = 8'hE5;
		ctl.send(1'b1, {gct_pkg::GRP_TALK, ADDR});
		ctl.poll(b);
		chk(b, 8'hA5);
		ctl.send(1'b1, gct_pkg::CMD_SPD);
		chk(poll_enabled, 1'b0);
	endtask
	task automatic close_out;
		$display("errors %0d checks %0d", error_cnt, n_tests);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	initial begin
		rstn = 1'b0;
		cfg_wr = 1'b0;
		srq_req = 1'b0;
		cfg_wdata = '0;
		status_byte = 8'h00;
		setup1 = gct_pkg::MEAS_DEFAULT;
		repeat (8) @(posedge core_clk);
		@(negedge core_clk);
		rstn = 1'b1;
		repeat (8) @(negedge core_clk);
		t_reset();
		t_dcl();
		t_sdc();
		t_get();
		t_poll();
		close_out();
	end
	// Whole run needs a few hundred cycles; this limit is far beyond it.
	initial begin
		#100000;
		error_cnt++;
		close_out();
	end
endmodule

// ### verilog/gct_clear_trigger_poll.sv
// Device end of the bus: clear messages, group trigger and serial poll.
// Assumes the pads invert nothing: every bus pin here is active low, and
// each open-drain line is pulled high outside while no output enable is set.
`timescale 1ns/1ns

// Operation
// - Universal clear restores every mode to default.
// - Defaults: 2nF, 100kHz, filter, 10/s, 450 count.
// - Measurement defaults come from setup slot 1.
// - Clear cancels drift correction and its constants.
// - Primary address survives any clear message.
// - Selective clear acts only when addressed listener.
// - Group trigger starts reading only with bus source.
// - Poll-enabled talker drives status byte when ATN released.
// - Each talk address gets its own status byte.
// - Status byte flags this device's service request.
module gct_clear_trigger_poll (
	// Clock and reset.
	input wire logic core_clk,
	input wire logic rstn,
	// Bus control lines, active low.
	input wire logic atn_n_i,
	input wire logic dav_n_i,
	output logic dav_n_o,
	output logic dav_n_oe,
	input wire logic nrfd_n_i,
	output logic nrfd_n_o,
	output logic nrfd_n_oe,
	input wire logic ndac_n_i,
	output logic ndac_n_o,
	output logic ndac_n_oe,
	output logic srq_n_o,
	output logic srq_n_oe,
	// Bus data lines, active low.
	input wire logic [7:0] dio_n_i,
	output logic [7:0] dio_n_o,
	output logic [7:0] dio_n_oe,
	// Instrument side controls.
	input wire logic [4:0] bus_addr,
	input wire gct_pkg::gct_meas_s setup1,
	input wire logic cfg_wr,
	input wire gct_pkg::gct_cfg_s cfg_wdata,
	input wire logic [7:0] status_byte,
	input wire logic srq_req,
	// Instrument side results.
	output gct_pkg::gct_cfg_s cfg,
	output logic drift_clr,
	output logic meas_start,
	output logic sweep_start,
	output logic restore_busy,
	output logic listen_active,
	output logic talk_active,
	output logic poll_enabled,
	output logic rx_valid,
	output logic [7:0] rx_data
);

	// Whole state and its next value.
	gct_pkg::gct_state_s s_q;
	gct_pkg::gct_state_s s_d;

	// Synchronised, active-high views of the bus lines.
	logic atn;
	logic dav;
	logic nrfd;
	logic ndac;
	logic [7:0] dio;
	// True while the block is a poll-enabled talker with ATN released.
	logic poll_talk;
	// Byte offered to the controller during a serial poll.
	logic [7:0] poll_byte;
	// Byte accepted and decoded in this cycle.
	logic take;
	// True when a clear of either kind must start.
	logic clear_hit;

	// Matches an address byte of a given group against the programmed address.
	function automatic logic addr_match(input logic [7:0] b, input logic [2:0] grp,
		input logic [4:0] addr);
		addr_match = (b[7:5] == grp) && (b[4:0] == addr);
	endfunction

	// Second synchroniser stage is the only one the logic looks at.
	assign atn = s_q.atn_s[1];
	assign dav = s_q.dav_s[1];
	assign nrfd = s_q.nrfd_s[1];
	assign ndac = s_q.ndac_s[1];
	assign dio = s_q.dio_s[15:8];

	// Status byte with bit 6 replaced by this device's own request flag.
	assign poll_byte = {status_byte[7], s_q.srq_pend, status_byte[5:0]};

	// Talker output only runs with ATN released and poll mode on.
	assign poll_talk = s_q.talk && s_q.spe && !atn;

	// A byte is taken only from the ready state once no restore is running.
	assign take = (s_q.ah == gct_pkg::AH_READY) && dav && (atn || s_q.listen) &&
		(s_q.restore_cnt == 3'h0);

	// Universal clear needs no address, selective clear needs our listen address.
	assign clear_hit = take && atn && ((dio == gct_pkg::CMD_DCL) ||
		((dio == gct_pkg::CMD_SDC) && s_q.listen));

	// Next-state logic for the whole block.
	always_comb begin
		s_d = s_q;
		// Pulses last one cycle.
		s_d.drift_clr = 1'b0;
		s_d.meas_start = 1'b0;
		s_d.sweep_start = 1'b0;
		s_d.rx_valid = 1'b0;

		// Two-flop synchronisers on every incoming pin, inverted to active high.
		s_d.atn_s = {s_q.atn_s[0], ~atn_n_i};
		s_d.dav_s = {s_q.dav_s[0], ~dav_n_i};
		s_d.nrfd_s = {s_q.nrfd_s[0], ~nrfd_n_i};
		s_d.ndac_s = {s_q.ndac_s[0], ~ndac_n_i};
		s_d.dio_s = {s_q.dio_s[7:0], ~dio_n_i};

		// Software writes of the operating set are ignored during a restore,
		// so a late write cannot undo a clear the controller just sent.
		if (cfg_wr && (s_q.restore_cnt == 3'h0)) begin
			s_d.cfg = cfg_wdata;
		end

		// Restore countdown; the defaults land on the last count.
		if (s_q.restore_cnt != 3'h0) begin
			s_d.restore_cnt = s_q.restore_cnt - 3'h1;
			if (s_q.restore_cnt == 3'h1) begin
				// Measurement modes follow the saved slot, the rest are fixed.
				s_d.cfg.meas = setup1;
				s_d.cfg.srq_mask = gct_pkg::SERVICE_REQUEST_MASK_DEFAULT;
				s_d.cfg.term_code = gct_pkg::TERMINATOR_CODE_DEFAULT;
				// Drift correction is turned off and its constants dropped.
				s_d.cfg.drift_correction_setting = 1'b0;
				s_d.drift_clr = 1'b1;
			end
		end

		// Acceptor handshake: commands under ATN, data bytes when listening.
		case (s_q.ah)
			gct_pkg::AH_READY: begin
				if (!(atn || s_q.listen)) begin
					// Not a party to this transfer: acceptance floats, but ready stays
					// held while a restore runs, so no byte can slip in before it ends.
					s_d.nrfd_oe = (s_q.restore_cnt != 3'h0);
					s_d.ndac_oe = 1'b0;
				end else if (take) begin
					// Byte captured: not ready for another, not yet accepted.
					s_d.nrfd_oe = 1'b1;
					s_d.ndac_oe = 1'b1;
					s_d.ah = gct_pkg::AH_TAKE;
				end else begin
					// Ready only once any restore has run out.
					s_d.nrfd_oe = (s_q.restore_cnt != 3'h0);
					s_d.ndac_oe = 1'b1;
				end
			end
			gct_pkg::AH_TAKE: begin
				// Acceptance is withheld while a clear is still being applied.
				if (s_q.restore_cnt == 3'h0) begin
					s_d.ndac_oe = 1'b0;
					s_d.ah = gct_pkg::AH_DONE;
				end
			end
			gct_pkg::AH_DONE: begin
				// Wait for the controller to drop data valid.
				if (!dav) begin
					s_d.ndac_oe = 1'b1;
					s_d.ah = gct_pkg::AH_READY;
				end
			end
			default: begin
				s_d.ah = gct_pkg::AH_READY;
			end
		endcase

		// Command and data decode on the byte just taken.
		if (take && atn) begin
			if (addr_match(dio, gct_pkg::GRP_LISTEN, bus_addr)) begin
				// Own listen address also makes the talker idle.
				s_d.listen = 1'b1;
				s_d.talk = 1'b0;
			end else if (dio == gct_pkg::CMD_UNL) begin
				s_d.listen = 1'b0;
			end else if (addr_match(dio, gct_pkg::GRP_TALK, bus_addr)) begin
				// Own talk address; listener goes idle.
				s_d.talk = 1'b1;
				s_d.listen = 1'b0;
			end else if ((dio[7:5] == gct_pkg::GRP_TALK) || (dio == gct_pkg::CMD_UNT)) begin
				// Another talker addressed, or untalk: drop talk.
				s_d.talk = 1'b0;
			end else if (dio == gct_pkg::CMD_SPE) begin
				s_d.spe = 1'b1;
			end else if (dio == gct_pkg::CMD_SPD) begin
				s_d.spe = 1'b0;
			end else if ((dio == gct_pkg::CMD_GET) && s_q.listen) begin
				// Trigger only when the bus trigger source is selected.
				if (s_q.cfg.meas.trig_src == gct_pkg::TRIG_SRC_GET) begin
					s_d.sweep_start = s_q.cfg.meas.trig_sweep;
					s_d.meas_start = !s_q.cfg.meas.trig_sweep;
				end
			end
		end else if (take) begin
			// Device-dependent byte, passed on for the command parser.
			s_d.rx_valid = 1'b1;
			s_d.rx_data = dio;
		end

		// Clear of either kind; the bus address is not part of the restored set.
		if (clear_hit) begin
			s_d.restore_cnt = gct_pkg::RESTORE_CYCLES;
		end
		// Busy is kept as its own flop so the output carries no decode logic.
		s_d.busy = (s_d.restore_cnt != 3'h0);

		// A status byte goes out once per ATN release, so each talk address
		// the controller sends during the poll gets a fresh answer.
		if (atn) begin
			s_d.sent = 1'b0;
		end

		// Source handshake for the status byte.
		case (s_q.sh)
			gct_pkg::SH_IDLE: begin
				s_d.dav_oe = 1'b0;
				s_d.dio_oe = 8'h00;
				if (poll_talk && !s_q.sent) begin
					// A set bit pulls its data line low.
					s_d.dio_oe = poll_byte;
					s_d.sh = gct_pkg::SH_WAIT;
				end
			end
			gct_pkg::SH_WAIT: begin
				if (!poll_talk) begin
					// ATN came back early: abandon the byte at once.
					s_d.dio_oe = 8'h00;
					s_d.sh = gct_pkg::SH_IDLE;
				end else if (!nrfd) begin
					// Every listener ready, data settled for a full cycle.
					s_d.dav_oe = 1'b1;
					s_d.sh = gct_pkg::SH_DAV;
				end
			end
			gct_pkg::SH_DAV: begin
				if (!poll_talk) begin
					s_d.dav_oe = 1'b0;
					s_d.dio_oe = 8'h00;
					s_d.sh = gct_pkg::SH_IDLE;
				end else if (!ndac) begin
					// Accepted: the reported request has now been seen.
					s_d.dav_oe = 1'b0;
					s_d.dio_oe = 8'h00;
					s_d.sent = 1'b1;
					s_d.srq_pend = 1'b0;
					s_d.sh = gct_pkg::SH_IDLE;
				end
			end
			default: begin
				s_d.sh = gct_pkg::SH_IDLE;
			end
		endcase

		// A new request in the same cycle as the poll read is kept.
		if (srq_req) begin
			s_d.srq_pend = 1'b1;
		end
	end

	// The one register bank; reset loads constants and starts a restore.
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			s_q <= gct_pkg::STATE_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	// Open-drain pins only ever pull low; the enable decides.
	assign dav_n_o = 1'b0;
	assign nrfd_n_o = 1'b0;
	assign ndac_n_o = 1'b0;
	assign srq_n_o = 1'b0;
	assign dio_n_o = 8'h00;
	assign dav_n_oe = s_q.dav_oe;
	assign nrfd_n_oe = s_q.nrfd_oe;
	assign ndac_n_oe = s_q.ndac_oe;
	assign srq_n_oe = s_q.srq_pend;
	assign dio_n_oe = s_q.dio_oe;

	// Instrument side results, each a flop of the state.
	assign cfg = s_q.cfg;
	assign drift_clr = s_q.drift_clr;
	assign meas_start = s_q.meas_start;
	assign sweep_start = s_q.sweep_start;
	assign restore_busy = s_q.busy;
	assign listen_active = s_q.listen;
	assign talk_active = s_q.talk;
	assign poll_enabled = s_q.spe;
	assign rx_valid = s_q.rx_valid;
	assign rx_data = s_q.rx_data;

endmodule

// ### verilog/gct_pkg.sv
// Shared constants and types for the bus clear, trigger and serial poll block.
// Assumes bus lines are active low and reach the block through pad buffers.
package gct_pkg;

	// Interface command bytes as seen after inverting the active-low data lines.
	localparam logic [7:0] CMD_DCL = 8'h14;
	localparam logic [7:0] CMD_SDC = 8'h04;
	localparam logic [7:0] CMD_GET = 8'h08;
	localparam logic [7:0] CMD_SPE = 8'h18;
	localparam logic [7:0] CMD_SPD = 8'h19;
	localparam logic [7:0] CMD_UNL = 8'h3F;
	localparam logic [7:0] CMD_UNT = 8'h5F;
	// Upper three bits that mark listen and talk address groups.
	localparam logic [2:0] GRP_LISTEN = 3'h1;
	localparam logic [2:0] GRP_TALK = 3'h2;

	// Trigger source code that selects the bus group trigger.
	localparam logic [2:0] TRIG_SRC_GET = 3'h2;
	// Clock cycles the default restore occupies while the handshake is held.
	localparam logic [2:0] RESTORE_CYCLES = 3'h4;

	// Measurement modes that follow stored setup slot one.
	typedef struct packed {
		logic [2:0] range_code;
		logic [1:0] freq_code;
		logic filter_on;
		logic [2:0] rate_code;
		logic zero_on;
		logic trig_sweep;
		logic [2:0] trig_src;
		logic bias_on;
		logic [1:0] wave_code;
		logic [7:0] bias_first;
		logic [7:0] bias_last;
		logic [7:0] bias_step;
		logic [7:0] bias_dflt;
		logic [15:0] bias_count;
	} gct_meas_s;

	// Whole configurable operating set.
	typedef struct packed {
		gct_meas_s meas;
		logic [7:0] srq_mask;
		logic [1:0] term_code;
		logic drift_correction_setting;
	} gct_cfg_s;

	// Fixed defaults used at power-up; only the mask and terminator ones are also used on either clear message.
	localparam logic [2:0] RANGE_CODE_DEFAULT = 3'h4;
	localparam logic [1:0] FREQUENCY_CODE_DEFAULT = 2'h0;
	localparam logic [2:0] RATE_CODE_DEFAULT = 3'h3;
	localparam logic [7:0] SERVICE_REQUEST_MASK_DEFAULT = 8'h00;
	localparam logic [1:0] TERMINATOR_CODE_DEFAULT = 2'h0;
	localparam logic [15:0] BIAS_COUNT_DEFAULT = 16'h01C2;
	localparam logic [2:0] TRIG_SRC_DEFAULT = 3'h1;

	localparam gct_meas_s MEAS_DEFAULT = '{
		range_code: RANGE_CODE_DEFAULT, freq_code: FREQUENCY_CODE_DEFAULT,
		filter_on: 1'b1, rate_code: RATE_CODE_DEFAULT, zero_on: 1'b0,
		trig_sweep: 1'b1, trig_src: TRIG_SRC_DEFAULT, bias_on: 1'b0,
		wave_code: 2'h0, bias_first: 8'h00, bias_last: 8'h00, bias_step: 8'h00,
		bias_dflt: 8'h00, bias_count: BIAS_COUNT_DEFAULT};

	// Acceptor handshake states; one bit changes per step except from done back to ready.
	typedef enum logic [1:0] {
		AH_READY = 2'h0,
		AH_TAKE = 2'h1,
		AH_DONE = 2'h3
	} gct_ah_e;

	// Source handshake states for the status byte.
	typedef enum logic [1:0] {
		SH_IDLE = 2'h0,
		SH_WAIT = 2'h1,
		SH_DAV = 2'h3
	} gct_sh_e;

	// Complete register state of the block.
	typedef struct packed {
		logic [1:0] atn_s;
		logic [1:0] dav_s;
		logic [1:0] nrfd_s;
		logic [1:0] ndac_s;
		logic [15:0] dio_s;
		gct_ah_e ah;
		gct_sh_e sh;
		gct_cfg_s cfg;
		logic [2:0] restore_cnt;
		// Registered copy of a nonzero restore count, for the busy output.
		logic busy;
		logic listen;
		logic talk;
		logic spe;
		logic sent;
		logic srq_pend;
		logic drift_clr;
		logic meas_start;
		logic sweep_start;
		logic rx_valid;
		logic [7:0] rx_data;
		logic nrfd_oe;
		logic ndac_oe;
		logic dav_oe;
		logic [7:0] dio_oe;
	} gct_state_s;

	localparam gct_state_s STATE_RESET = '{
		ah: AH_READY, sh: SH_IDLE,
		cfg: '{meas: MEAS_DEFAULT, srq_mask: SERVICE_REQUEST_MASK_DEFAULT,
			term_code: TERMINATOR_CODE_DEFAULT, drift_correction_setting: 1'b0},
		restore_cnt: RESTORE_CYCLES, busy: 1'b1, nrfd_oe: 1'b1, ndac_oe: 1'b1,
		default: '0};

endpackage
